// ### tff_pkg.sv
// Constants and types of the transmit FIFO status flag block.
package tff_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int NUM_EP     = 4;
	localparam int EP_W       = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W      = 5;
	localparam int ADDR_W     = 10;

	// ------------------------------------------------------------------
	// Register map (flag register index times four is its byte address)
	// ------------------------------------------------------------------
	localparam logic [7:0]        FLAGS_IDX     = 8'hF5;
	localparam logic [ADDR_W-1:0] FLAGS_ADDR    = {FLAGS_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] EPSEL_ADDR    = 10'h3C0;
	localparam logic [ADDR_W-1:0] INT_STAT_ADDR = 10'h3C4;
	localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 10'h3C8;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int FLG_EMPTY = 3;
	localparam int FLG_FULL  = 2;
	localparam int FLG_URF   = 1;
	localparam int FLG_OVF   = 0;
	localparam int INT_OVF   = 0;
	localparam int INT_URF   = 1;

	localparam logic [7:0]      FLAGS_RST    = 8'h08;
	localparam logic [EP_W-1:0] EPSEL_RST    = 2'h0;
	localparam logic [1:0]      INT_RST      = 2'h0;
	localparam logic [PTR_W-1:0] PTR_RST     = 5'h00;
	localparam logic [1:0]      RESP_OKAY    = 2'h0;
	localparam logic [1:0]      RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef logic [NUM_EP-1:0][PTR_W-1:0] tff_ptr_arr_t;
	typedef logic [NUM_EP-1:0]            tff_ep_bits_t;

	typedef struct packed {
		tff_ptr_arr_t      wp;
		tff_ptr_arr_t      rp;
		tff_ptr_arr_t      rm;
		tff_ep_bits_t      emp;
		tff_ep_bits_t      full;
		tff_ep_bits_t      urf;
		tff_ep_bits_t      ovf;
		logic [EP_W-1:0]   ep_sel;
		logic [1:0]        int_stat;
		logic [1:0]        int_mask;
		logic              irq;
		logic              nak;
		logic              data_hs;
		logic              aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_have;
		logic [7:0]        w_data;
		logic              w_lane0;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} tff_state_t;

endpackage

// ### tff_tx_fifo_flags.sv
// Transmit FIFO status flags per endpoint with an AXI4-Lite register slave.

// Functional notes
// - Empty flag (bit 3) is set while write pointer equals read pointer.
// - Empty flag clears as soon as the two pointers differ.
// - Full flag (bit 2) sets when wrapped write pointer equals read marker.
// - Full flag clears once the full condition is gone.
// - Full flag is read-only; software writes leave it unchanged.
// - One flag register shows the endpoint chosen by endpoint select.
// - Reset value of the flag register is 00xx 1000, bits 5:4 read zero.
// - Reading an empty FIFO sets a sticky underrun flag until firmware clears.
module tff_tx_fifo_flags
	import tff_pkg::*;
(
	input  wire logic              REF_CLK_IN,
	input  wire logic              SRST_IN,
	input  wire logic              TX_WR_IN,
	input  wire logic [EP_W-1:0]   TX_WR_EP_IN,
	input  wire logic              TX_RD_IN,
	input  wire logic              TX_ACK_IN,
	input  wire logic              TX_RETRY_IN,
	input  wire logic              IN_TOKEN_IN,
	input  wire logic [EP_W-1:0]   TX_SIE_EP_IN,
	output logic                   HS_NAK_OUT,
	output logic                   HS_DATA_OUT,
	output logic [NUM_EP-1:0]      TX_EMPTY_OUT,
	output logic [NUM_EP-1:0]      TX_FULL_OUT,
	output logic                   IRQ_OUT,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
	input  wire logic              S_AXI_AWVALID_IN,
	output logic                   S_AXI_AWREADY_OUT,
	input  wire logic [31:0]       S_AXI_WDATA_IN,
	input  wire logic [3:0]        S_AXI_WSTRB_IN,
	input  wire logic              S_AXI_WVALID_IN,
	output logic                   S_AXI_WREADY_OUT,
	output logic [1:0]             S_AXI_BRESP_OUT,
	output logic                   S_AXI_BVALID_OUT,
	input  wire logic              S_AXI_BREADY_IN,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
	input  wire logic              S_AXI_ARVALID_IN,
	output logic                   S_AXI_ARREADY_OUT,
	output logic [31:0]            S_AXI_RDATA_OUT,
	output logic [1:0]             S_AXI_RRESP_OUT,
	output logic                   S_AXI_RVALID_OUT,
	input  wire logic              S_AXI_RREADY_IN
);

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------
	function automatic tff_ep_bits_t empty_of(tff_ptr_arr_t wp,
		tff_ptr_arr_t rp);
		tff_ep_bits_t e;
		for (int i = 0; i < NUM_EP; i++)
		begin
			e[i] = (wp[i] == rp[i]);
		end
		return e;
	endfunction
	// Full means the write pointer is one lap ahead of the read marker.
	function automatic tff_ep_bits_t full_of(tff_ptr_arr_t wp,
		tff_ptr_arr_t rm);
		tff_ep_bits_t f;
		for (int i = 0; i < NUM_EP; i++)
		begin
			f[i] = (wp[i][PTR_W-2:0] == rm[i][PTR_W-2:0]) &&
				(wp[i][PTR_W-1] != rm[i][PTR_W-1]);
		end
		return f;
	endfunction
	function automatic logic [7:0] flag_byte(tff_state_t s,
		logic [EP_W-1:0] ep);
		logic [7:0] b;
		b = 8'h00;
		b[FLG_EMPTY] = s.emp[ep];
		b[FLG_FULL]  = s.full[ep];
		b[FLG_URF]   = s.urf[ep];
		b[FLG_OVF]   = s.ovf[ep];
		return b;
	endfunction

	function automatic logic [ADDR_W-1:0] word_of(logic [ADDR_W-1:0] a);
		return {a[ADDR_W-1:2], 2'b00};
	endfunction

	localparam tff_state_t STATE_RST = '{
		wp: '0, rp: '0, rm: '0,
		emp: {NUM_EP{FLAGS_RST[FLG_EMPTY]}},
		full: '0, urf: '0, ovf: '0,
		ep_sel: EPSEL_RST, int_stat: INT_RST, int_mask: INT_RST,
		irq: 1'b0, nak: 1'b0, data_hs: 1'b0,
		aw_have: 1'b0, aw_addr: '0, w_have: 1'b0, w_data: 8'h00,
		w_lane0: 1'b0, awready: 1'b0, wready: 1'b0,
		bvalid: 1'b0, bresp: RESP_OKAY, arready: 1'b0,
		rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY
	};

	tff_state_t state_reg;
	tff_state_t state_next;
	logic       wr_do;
	logic       wr_flags;
	logic [7:0] sel_byte;

	assign wr_do    = state_reg.aw_have && state_reg.w_have &&
		!state_reg.bvalid;
	assign wr_flags = wr_do && word_of(state_reg.aw_addr) == FLAGS_ADDR;
	assign sel_byte = flag_byte(state_reg, state_reg.ep_sel);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		logic [ADDR_W-1:0] ra;
		logic              urf_ev;
		logic              ovf_ev;
		state_next = state_reg;
		ra         = word_of(S_AXI_ARADDR_IN);
		urf_ev     = 1'b0;
		ovf_ev     = 1'b0;

		// A write beyond full is dropped and flagged as overrun.
		if (TX_WR_IN)
		begin
			if (state_reg.full[TX_WR_EP_IN])
			begin
				ovf_ev = 1'b1;
			end
			else
			begin
				state_next.wp[TX_WR_EP_IN] = state_reg.wp[TX_WR_EP_IN] +
					PTR_W'(1);
			end
		end
		// The read pointer parks at the empty position on underrun.
		if (TX_RETRY_IN)
		begin
			state_next.rp[TX_SIE_EP_IN] = state_reg.rm[TX_SIE_EP_IN];
		end
		else if (TX_RD_IN)
		begin
			if (state_reg.emp[TX_SIE_EP_IN])
			begin
				urf_ev = 1'b1;
			end
			else
			begin
				state_next.rp[TX_SIE_EP_IN] = state_reg.rp[TX_SIE_EP_IN] +
					PTR_W'(1);
			end
		end
		if (TX_ACK_IN)
		begin
			state_next.rm[TX_SIE_EP_IN] = state_reg.rp[TX_SIE_EP_IN];
		end
		// Flags follow the pointers in the same cycle they move.
		state_next.emp  = empty_of(state_next.wp, state_next.rp);
		state_next.full = full_of(state_next.wp, state_next.rm);

		// Write channel: address and data may arrive in either order.
		if (S_AXI_AWVALID_IN && state_reg.awready)
		begin
			state_next.aw_have = 1'b1;
			state_next.aw_addr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && state_reg.wready)
		begin
			state_next.w_have  = 1'b1;
			state_next.w_data  = S_AXI_WDATA_IN[7:0];
			state_next.w_lane0 = S_AXI_WSTRB_IN[0];
		end
		if (state_reg.bvalid && S_AXI_BREADY_IN)
		begin
			state_next.bvalid = 1'b0;
		end
		if (wr_do)
		begin
			state_next.aw_have = 1'b0;
			state_next.w_have  = 1'b0;
			state_next.bvalid  = 1'b1;
			state_next.bresp   = RESP_OKAY;
			unique case (word_of(state_reg.aw_addr))
				FLAGS_ADDR:
				begin
					// Error flags are clear-only: a zero clears, a one keeps.
					// Empty and full have no write path at all.
					if (state_reg.w_lane0 && !state_reg.w_data[FLG_URF])
					begin
						state_next.urf[state_reg.ep_sel] = 1'b0;
					end
					if (state_reg.w_lane0 && !state_reg.w_data[FLG_OVF])
					begin
						state_next.ovf[state_reg.ep_sel] = 1'b0;
					end
				end
				EPSEL_ADDR:
				begin
					if (state_reg.w_lane0)
					begin
						state_next.ep_sel = state_reg.w_data[EP_W-1:0];
					end
				end
				INT_MASK_ADDR:
				begin
					if (state_reg.w_lane0)
					begin
						state_next.int_mask = state_reg.w_data[1:0];
					end
				end
				INT_STAT_ADDR: state_next.bresp = RESP_OKAY;
				default:
				begin
					state_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Read channel; a status read clears it, events below still win.
		if (state_reg.rvalid && S_AXI_RREADY_IN)
		begin
			state_next.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_IN && state_reg.arready)
		begin
			state_next.rvalid = 1'b1;
			state_next.rresp  = RESP_OKAY;
			state_next.rdata  = 32'h0000_0000;
			unique case (ra)
				FLAGS_ADDR:
				begin
					state_next.rdata[7:0] = sel_byte;
				end
				EPSEL_ADDR:
				begin
					state_next.rdata[EP_W-1:0] = state_reg.ep_sel;
				end
				INT_STAT_ADDR:
				begin
					state_next.rdata[1:0] = state_reg.int_stat;
					state_next.int_stat   = INT_RST;
				end
				INT_MASK_ADDR:
				begin
					state_next.rdata[1:0] = state_reg.int_mask;
				end
				default:
				begin
					state_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		// Hardware sets come last so they win over any software clear.
		if (urf_ev)
		begin
			state_next.urf[TX_SIE_EP_IN] = 1'b1;
			state_next.int_stat[INT_URF] = 1'b1;
		end
		if (ovf_ev)
		begin
			state_next.ovf[TX_WR_EP_IN]  = 1'b1;
			state_next.int_stat[INT_OVF] = 1'b1;
		end
		state_next.irq = |(state_next.int_stat & state_next.int_mask);
		// Handshake choice for an IN token on the serial side.
		state_next.nak     = IN_TOKEN_IN && (state_reg.urf[TX_SIE_EP_IN] ||
			state_reg.ovf[TX_SIE_EP_IN]);
		state_next.data_hs = IN_TOKEN_IN && !(state_reg.urf[TX_SIE_EP_IN] ||
			state_reg.ovf[TX_SIE_EP_IN]);

		// One write and one read in flight; ready drops while one is held.
		state_next.awready = !state_next.aw_have && !state_next.bvalid;
		state_next.wready  = !state_next.w_have && !state_next.bvalid;
		state_next.arready = !state_next.rvalid;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			state_reg <= STATE_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign HS_NAK_OUT        = state_reg.nak;
	assign HS_DATA_OUT       = state_reg.data_hs;
	assign TX_EMPTY_OUT      = state_reg.emp;
	assign TX_FULL_OUT       = state_reg.full;
	assign IRQ_OUT           = state_reg.irq;
	assign S_AXI_AWREADY_OUT = state_reg.awready;
	assign S_AXI_WREADY_OUT  = state_reg.wready;
	assign S_AXI_BRESP_OUT   = state_reg.bresp;
	assign S_AXI_BVALID_OUT  = state_reg.bvalid;
	assign S_AXI_ARREADY_OUT = state_reg.arready;
	assign S_AXI_RDATA_OUT   = state_reg.rdata;
	assign S_AXI_RRESP_OUT   = state_reg.rresp;
	assign S_AXI_RVALID_OUT  = state_reg.rvalid;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (SRST_IN);

	logic quiet0;
	assign quiet0 = !TX_RD_IN && !TX_RETRY_IN && !TX_ACK_IN;
	property p_empty;
		TX_EMPTY_OUT == empty_of(state_reg.wp, state_reg.rp);
	endproperty
	a_empty: assert property (p_empty) else $error("empty mismatch");
	property p_empty_clr;
		(TX_WR_IN && !TX_FULL_OUT[TX_WR_EP_IN] && quiet0)
			|=> !TX_EMPTY_OUT[$past(TX_WR_EP_IN)];
	endproperty
	a_empty_clr: assert property (p_empty_clr) else $error("empty stuck");
	property p_full;
		TX_FULL_OUT == full_of(state_reg.wp, state_reg.rm);
	endproperty
	a_full: assert property (p_full) else $error("full mismatch");
	property p_full_clr;
		(TX_FULL_OUT[TX_SIE_EP_IN] && TX_ACK_IN && !TX_RETRY_IN &&
			!TX_WR_IN && state_reg.rp[TX_SIE_EP_IN] !=
			state_reg.rm[TX_SIE_EP_IN])
			|=> !TX_FULL_OUT[$past(TX_SIE_EP_IN)];
	endproperty
	a_full_clr: assert property (p_full_clr) else $error("full stuck");
	property p_full_ro;
		(wr_flags && !TX_WR_IN && !TX_ACK_IN && !TX_RETRY_IN)
			|=> $stable(TX_FULL_OUT);
	endproperty
	a_full_ro: assert property (p_full_ro) else $error("full written");
	property p_sel;
		(S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT &&
			word_of(S_AXI_ARADDR_IN) == FLAGS_ADDR) |=>
			S_AXI_RDATA_OUT[7:0] == $past(sel_byte) && S_AXI_RVALID_OUT;
	endproperty
	a_sel: assert property (p_sel) else $error("wrong flag byte");
	property p_rst;
		$fell(SRST_IN) |-> flag_byte(state_reg, 2'h0) == FLAGS_RST;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset flags");
	property p_nak;
		(IN_TOKEN_IN && (state_reg.urf[TX_SIE_EP_IN] ||
			state_reg.ovf[TX_SIE_EP_IN])) |=> HS_NAK_OUT && !HS_DATA_OUT;
	endproperty
	a_nak: assert property (p_nak) else $error("data sent in error");
	property p_urf;
		(TX_RD_IN && !TX_RETRY_IN && TX_EMPTY_OUT[TX_SIE_EP_IN]) |=>
			state_reg.urf[$past(TX_SIE_EP_IN)] ##1
			state_reg.urf[$past(TX_SIE_EP_IN, 2)];
	endproperty
	a_urf: assert property (p_urf) else $error("underrun lost");

	c_fill: cover property (TX_FULL_OUT[1] ##[1:100] TX_EMPTY_OUT[1]);
	c_nak: cover property (HS_NAK_OUT);
	c_irq: cover property ($rose(IRQ_OUT) ##[1:50] !IRQ_OUT);

endmodule

// ### tff_sie_model.sv
// Behavioural serial engine that reads bytes out of the transmit FIFOs.
module tff_sie_model
	import tff_pkg::*;
(
	input  wire logic            clk_in,
	output logic                 rd_out,
	output logic                 ack_out,
	output logic                 retry_out,
	output logic                 tok_out,
	output logic [EP_W-1:0]      ep_out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		{rd_out, ack_out, retry_out, tok_out} = 4'h0;
		ep_out = 2'h0;
	end

	// Kind 0 reads, 1 acknowledges, 2 retries, 3 is an IN token. The pulse
	// lasts n cycles and gap idle cycles follow, so a slow engine shows.
	task automatic op(input int kind, input logic [EP_W-1:0] ep,
		input int n, input int gap);
		@(posedge clk_in);
		ep_out    <= ep;
		rd_out    <= (kind == 0);
		ack_out   <= (kind == 1);
		retry_out <= (kind == 2);
		tok_out   <= (kind == 3);
		repeat (n) @(posedge clk_in);
		{rd_out, ack_out, retry_out, tok_out} <= 4'h0;
		// A stale endpoint must not pass for a live one, so it is inverted.
		ep_out <= ~ep;
		repeat (gap) @(posedge clk_in);
	endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the transmit FIFO status flag block.
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	err_total++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_top
	import tff_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic              wr = 1'b0;
	logic [EP_W-1:0]   wr_ep = 2'h0;
	logic [ADDR_W-1:0] awaddr = 10'h000;
	logic [ADDR_W-1:0] araddr = 10'h000;
	logic [31:0]       wdata = 32'h0;
	logic [3:0]        wstrb = 4'hF;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic              nak, dat, irq, awready, wready, bvalid;
	logic              arready, rvalid, s_rd, s_ack, s_rty, s_tok;
	logic [NUM_EP-1:0] emp, full;
	logic [1:0]        bresp, rresp, r2;
	logic [31:0]       rdata;
	logic [EP_W-1:0]   s_ep;
	logic [7:0]        d8;
	int                err_total = 0;
	int                samples_checked = 0;

	always #50 clk = ~clk;

	tff_tx_fifo_flags dut (.REF_CLK_IN(clk), .SRST_IN(srst),
		.TX_WR_IN(wr), .TX_WR_EP_IN(wr_ep), .TX_RD_IN(s_rd),
		.TX_ACK_IN(s_ack), .TX_RETRY_IN(s_rty), .IN_TOKEN_IN(s_tok),
		.TX_SIE_EP_IN(s_ep), .HS_NAK_OUT(nak), .HS_DATA_OUT(dat),
		.TX_EMPTY_OUT(emp), .TX_FULL_OUT(full), .IRQ_OUT(irq),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
		.S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
		.S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
		.S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
		.S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
		.S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
		.S_AXI_RREADY_IN(rready));

	tff_sie_model sie (.clk_in(clk), .rd_out(s_rd), .ack_out(s_ack),
		.retry_out(s_rty), .tok_out(s_tok), .ep_out(s_ep));

	task automatic conclude;
		$display("checked %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n > 40)
		begin
			err_total++;
			conclude();
		end
	endtask

	// Handshakes are judged at the falling edge, where all lines are still,
	// and acted on just after the next rising edge.
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [7:0] d,
		output logic [1:0] r);
		logic at, wt, bt;
		int   n;
		bt = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		{awvalid, wvalid, bready} <= 3'h7;
		while (!bt)
		begin
			@(negedge clk);
			at = awvalid && awready;
			wt = wvalid && wready;
			bt = bvalid && bready;
			r = bresp;
			@(posedge clk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
			if (bt) bready <= 1'b0;
			n++;
			tmo(n);
		end
	endtask

	task automatic axr(input logic [ADDR_W-1:0] a, output logic [7:0] d,
		output logic [1:0] r);
		logic at, rt;
		int   n;
		rt = 1'b0;
		n = 0;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		while (!rt)
		begin
			@(negedge clk);
			at = arvalid && arready;
			rt = rvalid && rready;
			d = rdata[7:0];
			r = rresp;
			@(posedge clk);
			if (at) arvalid <= 1'b0;
			if (rt) rready <= 1'b0;
			n++;
			tmo(n);
		end
	endtask

	task automatic chk_reg(input string nm, input logic [ADDR_W-1:0] a,
		input logic [7:0] e, input logic [1:0] er);
		axr(a, d8, r2);
		`CHK(nm, e, d8)
		`CHK("rresp", er, r2)
	endtask

	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		axw(a, d, r2);
		`CHK("bresp", RESP_OKAY, r2)
	endtask

	// Core writes back to back, one byte per cycle.
	task automatic push(input logic [EP_W-1:0] e, input int k);
		@(posedge clk);
		wr <= 1'b1;
		wr_ep <= e;
		repeat (k) @(posedge clk);
		wr <= 1'b0;
		wr_ep <= ~e;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1 `CHK("empty", 4'hF, emp)
		chk_reg("flags", FLAGS_ADDR, 8'h08, RESP_OKAY);
		wreg(INT_MASK_ADDR, 8'h03);
		wreg(EPSEL_ADDR, 8'h01);
		push(2'h1, FIFO_DEPTH);
		settle();
		`CHK("full", 4'h2, full)
		`CHK("empty", 4'hD, emp)
		chk_reg("flags", FLAGS_ADDR, 8'h04, RESP_OKAY);
		wreg(FLAGS_ADDR, 8'hFB);
		chk_reg("flags", FLAGS_ADDR, 8'h04, RESP_OKAY);
		`CHK("irq", 1'b0, irq)
		push(2'h1, 1);
		settle();
		`CHK("irq", 1'b1, irq)
		chk_reg("flags", FLAGS_ADDR, 8'h05, RESP_OKAY);
		sie.op(3, 2'h1, 1, 0);
		#1 `CHK("nak", 1'b1, nak)
		chk_reg("istat", INT_STAT_ADDR, 8'h01, RESP_OKAY);
		chk_reg("istat", INT_STAT_ADDR, 8'h00, RESP_OKAY);
		`CHK("irq", 1'b0, irq)
		wreg(FLAGS_ADDR, 8'hFE);
		sie.op(3, 2'h1, 1, 0);
		#1 `CHK("data", 1'b1, dat)
		wreg(EPSEL_ADDR, 8'h00);
		chk_reg("flags", FLAGS_ADDR, 8'h08, RESP_OKAY);
		wstrb <= 4'h0;
		wreg(EPSEL_ADDR, 8'h01);
		wstrb <= 4'hF;
		chk_reg("epsel", EPSEL_ADDR, 8'h00, RESP_OKAY);
		wreg(EPSEL_ADDR, 8'h01);
		sie.op(0, 2'h1, FIFO_DEPTH - 1, 2);
		settle();
		`CHK("empty", 4'hD, emp)
		sie.op(0, 2'h1, 1, 0);
		settle();
		`CHK("empty", 4'hF, emp)
		`CHK("full", 4'h2, full)
		sie.op(2, 2'h1, 1, 0);
		settle();
		`CHK("empty", 4'hD, emp)
		sie.op(0, 2'h1, FIFO_DEPTH, 0);
		sie.op(1, 2'h1, 1, 0);
		settle();
		`CHK("full", 4'h0, full)
		`CHK("empty", 4'hF, emp)
		sie.op(0, 2'h1, 1, 0);
		settle();
		chk_reg("flags", FLAGS_ADDR, 8'h0A, RESP_OKAY);
		sie.op(3, 2'h1, 1, 0);
		#1 `CHK("nak", 1'b1, nak)
		`CHK("irq", 1'b1, irq)
		chk_reg("istat", INT_STAT_ADDR, 8'h02, RESP_OKAY);
		wreg(FLAGS_ADDR, 8'hFD);
		chk_reg("flags", FLAGS_ADDR, 8'h08, RESP_OKAY);
		wreg(INT_MASK_ADDR, 8'h00);
		sie.op(0, 2'h2, 1, 0);
		settle();
		`CHK("irq", 1'b0, irq)
		chk_reg("istat", INT_STAT_ADDR, 8'h02, RESP_OKAY);
		axw(10'h100, 8'h00, r2);
		`CHK("bresp", RESP_SLVERR, r2)
		chk_reg("hole", 10'h100, 8'h00, RESP_SLVERR);
		chk_reg("imask", INT_MASK_ADDR, 8'h00, RESP_OKAY);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		chk_reg("epsel", EPSEL_ADDR, 8'h00, RESP_OKAY);
		wreg(EPSEL_ADDR, 8'h02);
		chk_reg("flags", FLAGS_ADDR, 8'h08, RESP_OKAY);
		conclude();
	end
endmodule
